// ===== logic/t0cp_pkg.sv
// Package for the timer0 counter with shared prescaler.
// Assumes a 10 MHz ref_clk and four clocks per instruction cycle.
package t0cp_pkg;

    // Register offsets on the plain register port
    localparam logic [7:0] T0CP_ADDR_COUNT   = 8'h01;
    localparam logic [7:0] T0CP_ADDR_OPTION  = 8'h81;
    localparam logic [7:0] T0CP_ADDR_INTCTRL = 8'h0B;

    // Option configuration register fields
    localparam int T0CP_OPT_CLK_SRC   = 5;
    localparam int T0CP_OPT_EDGE_SEL  = 4;
    localparam int T0CP_OPT_PRE_ASGN  = 3;
    localparam int T0CP_OPT_RATIO_LSB = 0;
    localparam int T0CP_RATIO_W       = 3;

    // Interrupt control register fields
    localparam int T0CP_INT_IRQ_EN = 5;
    localparam int T0CP_INT_OVF    = 2;

    // Reset values
    localparam logic [7:0] T0CP_COUNT_RST   = 8'h00;
    localparam logic [7:0] T0CP_OPTION_RST  = 8'hFF;
    localparam logic [7:0] T0CP_INTCTRL_RST = 8'h00;
    localparam logic [7:0] T0CP_RDATA_NONE  = 8'h00;

    // Timing: instruction cycle derived from the clock period
    localparam int T0CP_CLK_PERIOD_NS = 100;
    localparam int T0CP_INSTR_NS      = 400;
    localparam int T0CP_CLK_PER_INSTR = T0CP_INSTR_NS / T0CP_CLK_PERIOD_NS;
    localparam int T0CP_WR_INHIBIT    = 2;

    localparam logic [7:0] T0CP_COUNT_MAX = 8'hFF;

endpackage : t0cp_pkg

// ===== logic/t0cp_presc_if.sv
// Interface between the timer core and the shared prescaler.
// Assumes one clock domain; all signals are synchronous to ref_clk.
`timescale 1ns/10ps
`default_nettype none
interface t0cp_presc_if;
    import t0cp_pkg::*;
    logic                    srcTick;
    logic                    forWatchdog;
    logic [T0CP_RATIO_W-1:0] ratio;
    logic                    clear;
    logic                    outTick;

    modport owner  (output srcTick, output forWatchdog, output ratio,
                    output clear, input outTick);
    modport scaler (input srcTick, input forWatchdog, input ratio,
                    input clear, output outTick);
endinterface : t0cp_presc_if
`default_nettype wire

// ===== logic/t0cp_prescaler.sv
// Shared 8-bit prescaler, assigned either to timer0 or to the watchdog.
// Assumes srcTick is a one-cycle enable already selected by the owner.
`timescale 1ns/10ps
`default_nettype none
module t0cp_prescaler
    import t0cp_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic reset,
    t0cp_presc_if.scaler pif
);
    logic [7:0] preCount_r;
    logic [7:0] preCount_nxt;
    wire  [7:0] ratioMask;
    wire        terminal;

    // Timer0 ratios run 1:2..1:256; watchdog ratios run 1:1..1:128
    assign ratioMask = pif.forWatchdog
                     ? 8'((9'h001 << pif.ratio) - 9'h001)
                     : 8'((9'h002 << pif.ratio) - 9'h001);
    assign terminal  = (preCount_r & ratioMask) == ratioMask;
    assign pif.outTick = pif.srcTick && terminal;

    // Count is internal only; software never reaches it
    assign preCount_nxt = pif.clear ? 8'h00
                        : pif.outTick ? 8'h00
                        : pif.srcTick ? preCount_r + 8'h01
                        : preCount_r;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            preCount_r <= 8'h00;
        end else begin
            preCount_r <= preCount_nxt;
        end
    end
endmodule : t0cp_prescaler
`default_nettype wire

// ===== logic/t0cp_timer.sv
// Timer0 core: 8-bit timer/counter, shared prescaler, overflow interrupt.
// Assumes a plain register port on ref_clk and an asynchronous count pin.
`timescale 1ns/10ps
`default_nettype none

// Contract
// - 8-bit count register, read/write any time
// - source select clear counts instruction cycles
// - source select set counts pin edges
// - edge select: clear rising, set falling
// - count write inhibits next two instruction cycles
// - wrap FFh to 00h sets overflow flag
// - irq enable bit masks overflow request
// - sleep stops counter, no overflow in sleep
// - prescaler serves timer or watchdog, never both
// - prescaler count hidden from software
module t0cp_timer
    import t0cp_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       reset,
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWrData,
    input  wire logic       regWrStrobe,
    input  wire logic       regRdStrobe,
    output logic      [7:0] regRdData,
    input  wire logic       extCountInput,
    input  wire logic       sleepMode,
    input  wire logic       watchdogTick,
    output logic            watchdogTimeout,
    output logic            irq,
    output logic            instrCycle
);
    logic [7:0] timer0Count_r;
    logic [7:0] timer0Count_nxt;
    logic [7:0] option_r;
    logic [7:0] option_nxt;
    logic [7:0] intCtrl_r;
    logic [7:0] intCtrl_nxt;
    logic [7:0] rdData_r;
    logic [1:0] phase_r;
    logic [1:0] inhibit_r;
    logic [1:0] inhibit_nxt;
    logic       pinMeta_r;
    logic       pinSync_r;
    logic       pinLast_r;
    logic       instrTick_r;

    t0cp_presc_if pif ();

    wire wrCount   = regWrStrobe && (regAddr == T0CP_ADDR_COUNT);
    wire wrOption  = regWrStrobe && (regAddr == T0CP_ADDR_OPTION);
    wire wrIntCtrl = regWrStrobe && (regAddr == T0CP_ADDR_INTCTRL);

    wire clockSourceSelect = option_r[T0CP_OPT_CLK_SRC];
    wire sourceEdgeSelect  = option_r[T0CP_OPT_EDGE_SEL];
    wire prescToWatchdog   = option_r[T0CP_OPT_PRE_ASGN];
    wire overflowIrqEnable = intCtrl_r[T0CP_INT_IRQ_EN];
    wire overflowFlag      = intCtrl_r[T0CP_INT_OVF];

    // Rising edge when edge select is clear, falling when set
    wire pinRise = pinSync_r && !pinLast_r;
    wire pinFall = !pinSync_r && pinLast_r;
    wire pinEdge = sourceEdgeSelect ? pinFall : pinRise;

    // Mode picks instruction cycles or pin edges
    wire rawTick = clockSourceSelect ? pinEdge : instrTick_r;

    // Only one owner feeds the prescaler at a time
    assign pif.forWatchdog = prescToWatchdog;
    assign pif.srcTick     = prescToWatchdog ? watchdogTick
                                             : (rawTick && !sleepMode);
    assign pif.ratio       = option_r[T0CP_OPT_RATIO_LSB +: T0CP_RATIO_W];
    // Rewriting the count or option restarts the prescaler phase
    assign pif.clear       = wrCount || wrOption;

    wire timerTick = prescToWatchdog ? rawTick : pif.outTick;
    assign watchdogTimeout = prescToWatchdog ? pif.outTick
                                             : watchdogTick;

    // Sleep freezes the count so no overflow can happen
    wire countEnable = timerTick && !sleepMode && (inhibit_r == 2'd0);
    wire wrapEvent   = countEnable && (timer0Count_r == T0CP_COUNT_MAX);

    t0cp_prescaler u_prescaler (
        .ref_clk (ref_clk),
        .reset   (reset),
        .pif     (pif.scaler)
    );

    // Software write wins over a same-cycle increment
    assign timer0Count_nxt = wrCount ? regWrData
                           : countEnable ? timer0Count_r + 8'h01
                           : timer0Count_r;

    // Two instruction cycles of inhibit after a count write
    assign inhibit_nxt = wrCount ? 2'(T0CP_WR_INHIBIT)
                       : (instrTick_r && inhibit_r != 2'd0)
                         ? inhibit_r - 2'd1
                       : inhibit_r;

    assign option_nxt = wrOption ? regWrData : option_r;

    // Flag is write-one-to-clear; a wrap in that cycle still sets it
    always_comb begin
        intCtrl_nxt = intCtrl_r;
        if (wrIntCtrl) begin
            intCtrl_nxt = regWrData;
            intCtrl_nxt[T0CP_INT_OVF] =
                overflowFlag && !regWrData[T0CP_INT_OVF];
        end
        if (wrapEvent) begin
            intCtrl_nxt[T0CP_INT_OVF] = 1'b1;
        end
    end

    // Request stands while flag and enable are both set
    assign irq = overflowFlag && overflowIrqEnable;

    wire [7:0] rdMux = (regAddr == T0CP_ADDR_COUNT)   ? timer0Count_r
                     : (regAddr == T0CP_ADDR_OPTION)  ? option_r
                     : (regAddr == T0CP_ADDR_INTCTRL) ? intCtrl_r
                     : T0CP_RDATA_NONE;
    assign regRdData  = rdData_r;
    assign instrCycle = instrTick_r;

    // Instruction-cycle enable from the clock divider
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            phase_r     <= 2'd0;
            instrTick_r <= 1'b0;
        end else begin
            phase_r     <= (phase_r == 2'(T0CP_CLK_PER_INSTR - 1))
                         ? 2'd0 : phase_r + 2'd1;
            instrTick_r <= (phase_r == 2'(T0CP_CLK_PER_INSTR - 1));
        end
    end

    // Count pin crosses two flops before edge detection
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pinMeta_r <= 1'b0;
            pinSync_r <= 1'b0;
            pinLast_r <= 1'b0;
        end else begin
            pinMeta_r <= extCountInput;
            pinSync_r <= pinMeta_r;
            pinLast_r <= pinSync_r;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            timer0Count_r <= T0CP_COUNT_RST;
            option_r      <= T0CP_OPTION_RST;
            intCtrl_r     <= T0CP_INTCTRL_RST;
            inhibit_r     <= 2'd0;
            rdData_r      <= T0CP_RDATA_NONE;
        end else begin
            timer0Count_r <= timer0Count_nxt;
            option_r      <= option_nxt;
            intCtrl_r     <= intCtrl_nxt;
            inhibit_r     <= inhibit_nxt;
            rdData_r      <= regRdStrobe ? rdMux : T0CP_RDATA_NONE;
        end
    end
endmodule : t0cp_timer
`default_nettype wire

// ===== sim/t0cp_pulse_src.sv
// Pulse source model for the external count pin.
// Assumes the bench steps it between register accesses.
`timescale 1ns/10ps
`default_nettype none
module t0cp_pulse_src (
    input  wire logic ref_clk,
    output var  logic pin
);
    initial pin = 1'b0;
    // Each level is held 6 clocks so the two-flop sync always sees it
    task automatic step(input logic lvl);
        @(posedge ref_clk) pin <= lvl;
        repeat (6) @(posedge ref_clk);
    endtask : step
endmodule : t0cp_pulse_src
`default_nettype wire

// ===== sim/t0cp_timer_properties.sv
// Port-level checks for the timer0 block.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module t0cp_timer_properties
    import t0cp_pkg::*;
(
    input wire logic       ref_clk,
    input wire logic       reset,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic       regWrStrobe,
    input wire logic       regRdStrobe,
    input wire logic [7:0] regRdData,
    input wire logic       sleepMode,
    input wire logic       watchdogTick,
    input wire logic       watchdogTimeout,
    input wire logic       irq,
    input wire logic       instrCycle
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    wire logic unmappedAddr;
    assign unmappedAddr = regAddr != T0CP_ADDR_COUNT &&
        regAddr != T0CP_ADDR_OPTION && regAddr != T0CP_ADDR_INTCTRL;
    a_read_idle_zero: assert property (
        !$past(regRdStrobe) |-> regRdData == 8'h00) else $error("rd idle");
    a_unmapped_reads_zero: assert property (
        regRdStrobe && unmappedAddr |=> regRdData == 8'h00)
        else $error("unmapped read");
    a_reset_quiet: assert property (
        $past(reset) |-> !irq && regRdData == 8'h00) else $error("reset");
    a_instr_period: assert property (
        instrCycle |=> !instrCycle [*3] ##1 instrCycle) else $error("tick");
    a_flag_holds: assert property (
        irq && !regWrStrobe |=> irq) else $error("irq dropped");
    a_mask_drops: assert property (
        regWrStrobe && regAddr == T0CP_ADDR_INTCTRL &&
        !regWrData[T0CP_INT_IRQ_EN] |=> !irq) else $error("mask");
    a_sleep_no_wake: assert property (
        $rose(irq) |-> $past(regWrStrobe) || !$past(sleepMode))
        else $error("irq in sleep");
    a_wd_from_tick: assert property (
        watchdogTimeout |-> watchdogTick) else $error("watchdog timeout");
    cover property ($rose(irq));
    cover property (watchdogTimeout);
    cover property (regRdStrobe && regAddr == T0CP_ADDR_COUNT);
endmodule : t0cp_timer_properties
bind t0cp_timer t0cp_timer_properties u_props (.ref_clk, .reset,
    .regAddr, .regWrData, .regWrStrobe, .regRdStrobe, .regRdData,
    .sleepMode, .watchdogTick, .watchdogTimeout, .irq, .instrCycle);
`default_nettype wire

// ===== sim/t0cp_timer_test.sv
// Self-checking bench for the timer0 block and its pin model.
// Assumes a 10 MHz ref_clk and the package register map.
`timescale 1ns/10ps
`default_nettype none
module t0cp_timer_test
    import t0cp_pkg::*;
;
    logic       ref_clk = 1'b0;
    logic       reset, regWrStrobe, regRdStrobe, sleepMode, watchdogTick;
    logic       pin, irq, instrCycle, wdOut;
    logic [7:0] regAddr, regWrData, regRdData, v, w;
    int         num_errors = 0;
    int         tests_run = 0;
    always #50 ref_clk = ~ref_clk;
    t0cp_pulse_src u_src (.ref_clk(ref_clk), .pin(pin));
    t0cp_timer u_dut (.ref_clk(ref_clk), .reset(reset), .regAddr(regAddr),
        .regWrData(regWrData), .regWrStrobe(regWrStrobe),
        .regRdStrobe(regRdStrobe), .regRdData(regRdData),
        .extCountInput(pin), .sleepMode(sleepMode),
        .watchdogTick(watchdogTick), .watchdogTimeout(wdOut),
        .irq(irq), .instrCycle(instrCycle));
    task automatic check(input string n, input logic [7:0] s, e);
        tests_run++;
        if (s !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, d);
        @(posedge ref_clk);
        regAddr <= a;
        regWrData <= d;
        regWrStrobe <= 1'b1;
        @(posedge ref_clk);
        regWrStrobe <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regRdStrobe <= 1'b1;
        @(posedge ref_clk);
        regRdStrobe <= 1'b0;
        @(negedge ref_clk);
        d = regRdData;
    endtask : rd
    // Ends on the low phase of a tick, so the count settles at the next edge
    task automatic waitTicks(input int n);
        repeat (n) begin
            @(negedge ref_clk);
            while (instrCycle !== 1'b1) @(negedge ref_clk);
        end
    endtask : waitTicks
    task automatic wdTick(input logic [7:0] e);
        @(posedge ref_clk) watchdogTick <= 1'b1;
        @(negedge ref_clk);
        check("watchdog", {7'h00, wdOut}, e);
        @(posedge ref_clk) watchdogTick <= 1'b0;
    endtask : wdTick
    task automatic t_regs();
        rd(T0CP_ADDR_OPTION, v);
        check("option", v, T0CP_OPTION_RST);
        rd(8'h55, v);
        check("unmapped", v, 8'h00);
        wr(T0CP_ADDR_COUNT, 8'hA5);
        rd(T0CP_ADDR_COUNT, v);
        check("count", v, 8'hA5);
    endtask : t_regs
    task automatic t_timer();
        wr(T0CP_ADDR_OPTION, 8'h08);
        wr(T0CP_ADDR_COUNT, 8'h10);
        waitTicks(5);
        rd(T0CP_ADDR_COUNT, v);
        check("count", v, 8'h13);
    endtask : t_timer
    task automatic t_ovf();
        wr(T0CP_ADDR_INTCTRL, 8'h20);
        wr(T0CP_ADDR_COUNT, 8'hFD);
        waitTicks(5);
        @(negedge ref_clk);
        check("irq", {7'h00, irq}, 8'h01);
        wr(T0CP_ADDR_INTCTRL, 8'h00);
        rd(T0CP_ADDR_INTCTRL, v);
        check("irq", {7'h00, irq}, 8'h00);
        check("intctrl", v, 8'h04);
        wr(T0CP_ADDR_INTCTRL, 8'h04);
        rd(T0CP_ADDR_INTCTRL, v);
        check("intctrl", v, 8'h00);
    endtask : t_ovf
    task automatic t_sleep();
        wr(T0CP_ADDR_INTCTRL, 8'h20);
        wr(T0CP_ADDR_COUNT, 8'hFE);
        sleepMode <= 1'b1;
        repeat (40) @(posedge ref_clk);
        rd(T0CP_ADDR_COUNT, v);
        check("count", v, 8'hFE);
        check("irq", {7'h00, irq}, 8'h00);
        @(posedge ref_clk) sleepMode <= 1'b0;
    endtask : t_sleep
    task automatic t_edge();
        for (int i = 0; i < 2; i++) begin
            wr(T0CP_ADDR_OPTION, (i != 0) ? 8'h38 : 8'h28);
            wr(T0CP_ADDR_COUNT, 8'h00);
            waitTicks(3);
            u_src.step(1'b1);
            u_src.step(1'b0);
            u_src.step(1'b1);
            rd(T0CP_ADDR_COUNT, v);
            check("edges", v, (i != 0) ? 8'h01 : 8'h02);
            u_src.step(1'b0);
        end
    endtask : t_edge
    // Reads a whole number of prescaled periods apart, so phase cancels out
    task automatic t_presc();
        wr(T0CP_ADDR_OPTION, 8'h0F);
        wdTick(8'h00);
        for (int r = 0; r < 3; r++) begin
            wr(T0CP_ADDR_OPTION, 8'(r));
            waitTicks(1);
            rd(T0CP_ADDR_COUNT, v);
            waitTicks(8);
            rd(T0CP_ADDR_COUNT, w);
            check("ratio", w - v, 8'h04 >> r);
        end
        wdTick(8'h01);
    endtask : t_presc
    task automatic summarize();
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : summarize
    initial begin
        {regAddr, regWrData} = 16'h0000;
        {reset, regWrStrobe, regRdStrobe, sleepMode, watchdogTick} = 5'h10;
        repeat (6) @(posedge ref_clk);
        reset <= 1'b0;
        t_regs();
        t_timer();
        t_ovf();
        t_sleep();
        t_edge();
        t_presc();
        summarize();
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        summarize();
    end
endmodule : t0cp_timer_test
`default_nettype wire
